// ### rtl/ias_pkg.sv
// Shared constants and types of the interrupt arbitration sequencer
`default_nettype none

package ias_pkg;

  // Widths
  localparam int unsigned DATA_W    = 8;
  localparam int unsigned ADDR_W    = 4;
  localparam int unsigned LEVEL_W   = 3;
  localparam int unsigned PC_W      = 16;
  localparam int unsigned NUM_LEVEL = 8;

  // Register offsets
  localparam logic [ADDR_W-1:0] OFS_CTRL    = 4'h0;
  localparam logic [ADDR_W-1:0] OFS_NEST    = 4'h1;
  localparam logic [ADDR_W-1:0] OFS_SEGCFG  = 4'h2;
  localparam logic [ADDR_W-1:0] OFS_CODESEG = 4'h3;
  localparam logic [ADDR_W-1:0] OFS_INTSEG  = 4'h4;
  localparam logic [ADDR_W-1:0] OFS_VECPTR  = 4'h5;
  localparam logic [ADDR_W-1:0] OFS_STATUS  = 4'h6;

  // Field positions
  localparam int unsigned CTRL_LVL_LSB   = 0;
  localparam int unsigned CTRL_GIE_BIT   = 4;
  localparam int unsigned CTRL_MODE_BIT  = 5;
  localparam int unsigned SEGCFG_SSE_BIT = 0;
  localparam int unsigned STAT_BUSY_BIT  = 0;
  localparam int unsigned STAT_ALT_BIT   = 1;
  localparam int unsigned STAT_DEPTH_LSB = 4;
  localparam int unsigned DEPTH_W        = 4;

  // Reset values
  localparam logic [LEVEL_W-1:0]   LVL_RST   = 3'h7;
  localparam logic                 GIE_RST   = 1'b0;
  localparam logic                 MODE_RST  = 1'b0;
  localparam logic [NUM_LEVEL-1:0] NEST_RST  = 8'h00;
  localparam logic                 SSE_RST   = 1'b0;
  localparam logic [DATA_W-1:0]    SEG_RST   = 8'h00;
  localparam logic [DATA_W-1:0]    VECP_RST  = 8'h00;
  localparam logic [DEPTH_W-1:0]   DEPTH_RST = 4'h0;

  typedef enum logic [3:0] {
    ST_IDLE,
    ST_PUSH_PCL,
    ST_PUSH_PCH,
    ST_PUSH_SEG,
    ST_PUSH_FLG,
    ST_VEC_REQ,
    ST_VEC_WAIT,
    ST_VEC_TAKE,
    ST_POP_REQ,
    ST_POP_WAIT,
    ST_POP_TAKE
  } ias_state_t;

  typedef enum logic [1:0] {
    POP_FLG,
    POP_SEG,
    POP_PCH,
    POP_PCL
  } ias_pop_t;

endpackage : ias_pkg

`default_nettype wire

// ### rtl/ias_arbiter.sv
// Priority arbiter: lowest level wins, lowest channel index breaks ties
`default_nettype none

module ias_arbiter
  import ias_pkg::*;
#(
  parameter int unsigned NUM_CH = 16,
  parameter int unsigned CH_W   = 4
)
(
  // Requests
  input  wire logic [NUM_CH-1:0]         req_pending,
  input  wire logic [NUM_CH*LEVEL_W-1:0] req_level,
  // Winner
  output logic                           win_valid,
  output logic [LEVEL_W-1:0]             win_level,
  output logic [CH_W-1:0]                win_index
);

  logic [NUM_CH:0]      v_c;
  logic [LEVEL_W-1:0]   l_c [NUM_CH+1];
  logic [CH_W-1:0]      i_c [NUM_CH+1];

  assign v_c[0] = 1'b0;
  assign l_c[0] = LVL_RST;
  assign i_c[0] = '0;

  generate
    for (genvar g = 0; g < NUM_CH; g++)
    begin : g_stage
      logic [LEVEL_W-1:0] lvl;
      logic               take;
      assign lvl      = req_level[g*LEVEL_W +: LEVEL_W]; // RL24
      // Strict compare keeps the earlier channel on equal levels
      assign take     = req_pending[g] && (!v_c[g] || (lvl < l_c[g])); // RL4
      assign v_c[g+1] = v_c[g] | req_pending[g];
      assign l_c[g+1] = take ? lvl : l_c[g];
      assign i_c[g+1] = take ? CH_W'(g) : i_c[g];
    end
  endgenerate

  assign win_valid = v_c[NUM_CH];
  assign win_level = l_c[NUM_CH];
  assign win_index = i_c[NUM_CH];

endmodule : ias_arbiter

`default_nettype wire

// ### rtl/ias_sequencer.sv
// Interrupt arbitration, entry and return sequencer with register port
//
// Chosen here: strobed register access and the placing of the registers.
`default_nettype none

// Overview of operation
// RL1: Two arbitration modes, concurrent or nested, picked by one control bit.
// RL2: Mode bit clear means concurrent; it resets clear.
// RL3: Concurrent mode never changes the current level by hardware.
// RL4: Each instruction boundary arbitrates for the highest priority request.
// RL5: Acknowledge first clears the global enable.
// RL6: Entry pushes PC low, PC high, code segment if enabled, then flags.
// RL7: After pushes, PC loads the 16-bit vector chosen by the vector pointer.
// RL8: Entry copies interrupt segment to code segment, or fetches from it.
// RL9: Return pops flags, code segment if enabled, PC high, PC low.
// RL10: Return sets the global enable again after restoring the PC.
// RL11: Concurrent return without segment save resumes fetch from code segment.
// RL12: Requests while disabled stay pending until enable instruction runs.
// RL13: Concurrent mode keeps no serviced level; any pending request wins. The code still acknowledges only a level below the current level.
// RL14: Software should use the enable instruction in routines only when nested.
// RL15: Concurrent nesting needs segment save or equal segment pointers.
// RL16: Every service routine must end with the return instruction.
// RL17: Nested acknowledge sets the stack bit indexed by the current level.
// RL18: Nested acknowledge then loads the current level with request level.
// RL19: Nested entry: disable, save level, load level, then pushes and vector.
// RL20: Nested return restores the current level from the level stack.
// RL21: Nested return without save leaves interrupt segment while nested.
// RL22: Current level is 3-bit read/write, reset to 7.
// RL23: Acknowledge only when request level is strictly below current level.
// RL24: Each channel has a 3-bit level, 0 highest, 7 lowest.
// RL25: Restore takes the lowest set stack bit and clears it.
// RL26: All sequencing is clocked; reset clears level stack and enable.
module ias_sequencer
  import ias_pkg::*;
#(
  parameter int unsigned NUM_CH = 16,
  parameter int unsigned CH_W   = 4
)
(
  // Clock and reset
  input  wire logic                      clock,
  input  wire logic                      reset_n,
  // Register port
  input  wire logic [ADDR_W-1:0]         reg_addr,
  input  wire logic [DATA_W-1:0]         reg_wdata,
  input  wire logic                      reg_wr,
  input  wire logic                      reg_rd,
  output logic [DATA_W-1:0]              reg_rdata,
  // Interrupt requests
  input  wire logic [NUM_CH-1:0]         req_pending,
  input  wire logic [NUM_CH*LEVEL_W-1:0] req_level,
  // Instruction sequencer
  input  wire logic                      instr_boundary,
  input  wire logic                      enable_irq_exec,
  input  wire logic                      irq_return_exec,
  input  wire logic [PC_W-1:0]           pc_current,
  input  wire logic [DATA_W-1:0]         flags_current,
  // Acknowledge
  output logic                           ack_pulse,
  output logic [CH_W-1:0]                ack_channel,
  // System stack
  output logic                           stack_push,
  output logic                           stack_pop,
  output logic [DATA_W-1:0]              stack_wdata,
  input  wire logic [DATA_W-1:0]         stack_rdata,
  // Vector table
  output logic                           vec_read,
  output logic [DATA_W-1:0]              vec_addr,
  output logic [DATA_W-1:0]              vec_segment,
  input  wire logic [PC_W-1:0]           vec_data,
  // Core state loads
  output logic                           pc_load,
  output logic [PC_W-1:0]                pc_value,
  output logic                           flags_load,
  output logic [DATA_W-1:0]              flags_value,
  // Status
  output logic [DATA_W-1:0]              fetch_segment,
  output logic                           busy,
  output logic                           global_interrupt_enable,
  output logic [LEVEL_W-1:0]             current_priority_level
);

  ias_state_t             st_q, st_d;
  ias_pop_t               item_q, item_d;
  logic                   gie_q, gie_d;
  logic                   nested_q, nested_d;
  logic [LEVEL_W-1:0]     lvl_q, lvl_d;
  logic [NUM_LEVEL-1:0]   nest_q, nest_d;
  logic                   sse_q, sse_d;
  logic [DATA_W-1:0]      code_seg_q, code_seg_d;
  logic [DATA_W-1:0]      int_seg_q, int_seg_d;
  logic [DATA_W-1:0]      vec_ptr_q, vec_ptr_d;
  logic [DEPTH_W-1:0]     depth_q, depth_d;
  logic                   alt_q, alt_d;
  logic [CH_W-1:0]        ch_q, ch_d;
  logic [PC_W-1:0]        pc_sav_q, pc_sav_d;
  logic [DATA_W-1:0]      flg_sav_q, flg_sav_d;
  logic [DATA_W-1:0]      pch_q, pch_d;
  logic                   ack_q, ack_d;
  logic                   push_q, push_d;
  logic                   pop_q, pop_d;
  logic [DATA_W-1:0]      swd_q, swd_d;
  logic                   vrd_q, vrd_d;
  logic [DATA_W-1:0]      vaddr_q, vaddr_d;
  logic                   pcl_q, pcl_d;
  logic [PC_W-1:0]        pcv_q, pcv_d;
  logic                   fll_q, fll_d;
  logic [DATA_W-1:0]      flv_q, flv_d;
  logic [DATA_W-1:0]      fseg_q;
  logic [DATA_W-1:0]      rdata_q;
  logic                   busy_q;

  logic                   win_valid;
  logic [LEVEL_W-1:0]     win_level;
  logic [CH_W-1:0]        win_index;

  ias_arbiter #(
    .NUM_CH (NUM_CH),
    .CH_W   (CH_W)
  ) u_arb (
    .req_pending (req_pending),
    .req_level   (req_level),
    .win_valid   (win_valid),
    .win_level   (win_level),
    .win_index   (win_index)
  );

  // Decode
  wire logic wr_ctrl  = reg_wr && (reg_addr == OFS_CTRL);
  wire logic wr_nest  = reg_wr && (reg_addr == OFS_NEST);
  wire logic wr_seg   = reg_wr && (reg_addr == OFS_SEGCFG);
  wire logic wr_code  = reg_wr && (reg_addr == OFS_CODESEG);
  wire logic wr_int   = reg_wr && (reg_addr == OFS_INTSEG);
  wire logic wr_vecp  = reg_wr && (reg_addr == OFS_VECPTR);

  // Requests are never consumed here; disabled ones simply wait
  wire logic take_ack = (st_q == ST_IDLE) && instr_boundary && gie_q   // RL12
                        && win_valid && (win_level < lvl_q)            // RL23
                        && !irq_return_exec;
  wire logic take_ret = (st_q == ST_IDLE) && irq_return_exec;
  wire logic pop_last = (st_q == ST_POP_TAKE) && (item_q == POP_PCL);

  // Lowest set bit of the level stack is the most recent save
  wire logic [NUM_LEVEL-1:0] nest_low =
    nest_q & NUM_LEVEL'(~nest_q + NUM_LEVEL'(1));                     // RL25
  logic [LEVEL_W-1:0] low_idx;
  always_comb
  begin
    low_idx = LVL_RST;
    for (int i = NUM_LEVEL - 1; i >= 0; i--)
      if (nest_q[i])
        low_idx = LEVEL_W'(i);
  end
  wire logic [LEVEL_W-1:0] restore_lvl = (nest_q == NEST_RST) ? LVL_RST
                                                              : low_idx;

  wire logic [DATA_W-1:0] ctrl_rd =
    DATA_W'({nested_q, gie_q, 1'b0, lvl_q});
  wire logic [DATA_W-1:0] stat_rd =
    DATA_W'({depth_q, 2'b00, alt_q, (st_q != ST_IDLE)});
  wire logic [DATA_W-1:0] rd_mux =
    (reg_addr == OFS_CTRL)    ? ctrl_rd :
    (reg_addr == OFS_NEST)    ? nest_q :
    (reg_addr == OFS_SEGCFG)  ? DATA_W'(sse_q) :
    (reg_addr == OFS_CODESEG) ? code_seg_q :
    (reg_addr == OFS_INTSEG)  ? int_seg_q :
    (reg_addr == OFS_VECPTR)  ? vec_ptr_q :
    (reg_addr == OFS_STATUS)  ? stat_rd : '0;

  always_comb
  begin
    st_d       = st_q;
    item_d     = item_q;
    gie_d      = gie_q;
    nested_d   = nested_q;
    lvl_d      = lvl_q;
    nest_d     = nest_q;
    sse_d      = sse_q;
    code_seg_d = code_seg_q;
    int_seg_d  = int_seg_q;
    vec_ptr_d  = vec_ptr_q;
    depth_d    = depth_q;
    alt_d      = alt_q;
    ch_d       = ch_q;
    pc_sav_d   = pc_sav_q;
    flg_sav_d  = flg_sav_q;
    pch_d      = pch_q;
    ack_d      = 1'b0;
    push_d     = 1'b0;
    pop_d      = 1'b0;
    swd_d      = swd_q;
    vrd_d      = 1'b0;
    vaddr_d    = vaddr_q;
    pcl_d      = 1'b0;
    pcv_d      = pcv_q;
    fll_d      = 1'b0;
    flv_d      = flv_q;
    // Software writes first; sequencer updates below override them
    if (wr_ctrl)
    begin
      lvl_d    = reg_wdata[CTRL_LVL_LSB +: LEVEL_W];                  // RL22
      gie_d    = reg_wdata[CTRL_GIE_BIT];
      nested_d = reg_wdata[CTRL_MODE_BIT];                            // RL1
    end
    if (wr_nest)
      nest_d = reg_wdata;
    if (wr_seg)
      sse_d = reg_wdata[SEGCFG_SSE_BIT];
    if (wr_code)
      code_seg_d = reg_wdata;
    if (wr_int)
      int_seg_d = reg_wdata;
    if (wr_vecp)
      vec_ptr_d = reg_wdata;
    if (enable_irq_exec)
      gie_d = 1'b1;                                                   // RL12
    case (st_q)
      ST_IDLE:
      begin
        if (take_ret)
        begin
          item_d = POP_FLG;
          st_d   = ST_POP_REQ;
        end
        else if (take_ack)
        begin
          gie_d     = 1'b0;                                           // RL5
          ack_d     = 1'b1;
          ch_d      = win_index;
          pc_sav_d  = pc_current;
          flg_sav_d = flags_current;
          depth_d   = DEPTH_W'(depth_q + DEPTH_W'(1));
          // Concurrent mode leaves the level alone
          if (nested_q)                                          // RL3 RL13
          begin
            nest_d[lvl_q] = 1'b1;                                     // RL17
            lvl_d         = win_level;                                // RL18
          end
          st_d = ST_PUSH_PCL;                                         // RL19
        end
      end
      ST_PUSH_PCL:
      begin
        push_d = 1'b1;                                                // RL6
        swd_d  = pc_sav_q[DATA_W-1:0];
        st_d   = ST_PUSH_PCH;
      end
      ST_PUSH_PCH:
      begin
        push_d = 1'b1;                                                // RL6
        swd_d  = pc_sav_q[PC_W-1:DATA_W];
        st_d   = sse_q ? ST_PUSH_SEG : ST_PUSH_FLG;
      end
      ST_PUSH_SEG:
      begin
        push_d = 1'b1;                                                // RL6
        swd_d  = code_seg_q;
        st_d   = ST_PUSH_FLG;
      end
      ST_PUSH_FLG:
      begin
        push_d = 1'b1;                                                // RL6
        swd_d  = flg_sav_q;
        st_d   = ST_VEC_REQ;
      end
      ST_VEC_REQ:
      begin
        vrd_d   = 1'b1;                                               // RL7
        vaddr_d = DATA_W'(vec_ptr_q + DATA_W'({ch_q, 1'b0}));
        st_d    = ST_VEC_WAIT;
      end
      ST_VEC_WAIT:
        st_d = ST_VEC_TAKE;
      ST_VEC_TAKE:
      begin
        pcl_d = 1'b1;                                                 // RL7
        pcv_d = vec_data;
        if (sse_q)
          code_seg_d = int_seg_q;                                     // RL8
        else
          alt_d = 1'b1;                                               // RL8
        st_d = ST_IDLE;
      end
      ST_POP_REQ:
      begin
        pop_d = 1'b1;                                                 // RL9
        st_d  = ST_POP_WAIT;
      end
      ST_POP_WAIT:
        st_d = ST_POP_TAKE;
      ST_POP_TAKE:
      begin
        st_d = ST_POP_REQ;
        case (item_q)
          POP_FLG:
          begin
            fll_d  = 1'b1;                                            // RL9
            flv_d  = stack_rdata;
            item_d = sse_q ? POP_SEG : POP_PCH;
          end
          POP_SEG:
          begin
            code_seg_d = stack_rdata;                                 // RL9
            item_d     = POP_PCH;
          end
          POP_PCH:
          begin
            pch_d  = stack_rdata;                                     // RL9
            item_d = POP_PCL;
          end
          default:
          begin
            pcl_d   = 1'b1;                                           // RL9
            pcv_d   = {pch_q, stack_rdata};
            gie_d   = 1'b1;                                           // RL10
            st_d    = ST_IDLE;
            depth_d = (depth_q == DEPTH_RST) ? DEPTH_RST
                                             : DEPTH_W'(depth_q - DEPTH_W'(1));
            if (nested_q)
            begin
              lvl_d  = restore_lvl;                                   // RL20
              nest_d = nest_d & ~nest_low;                            // RL25
            end
            if (!sse_q && (!nested_q || (depth_q <= DEPTH_W'(1))))
              alt_d = 1'b0;                                           // RL11 RL21
          end
        endcase
      end
      default:
        st_d = ST_IDLE;
    endcase
  end

  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
    begin
      st_q     <= ST_IDLE;
      item_q   <= POP_FLG;
      gie_q    <= GIE_RST;                                            // RL26
      nested_q <= MODE_RST;                                           // RL2
      lvl_q    <= LVL_RST;                                            // RL22
      nest_q   <= NEST_RST;                                           // RL26
      sse_q    <= SSE_RST;
      depth_q  <= DEPTH_RST;
      alt_q    <= 1'b0;
    end
    else
    begin
      st_q     <= st_d;
      item_q   <= item_d;
      gie_q    <= gie_d;
      nested_q <= nested_d;
      lvl_q    <= lvl_d;
      nest_q   <= nest_d;
      sse_q    <= sse_d;
      depth_q  <= depth_d;
      alt_q    <= alt_d;
    end
  end

  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
    begin
      code_seg_q <= SEG_RST;
      int_seg_q  <= SEG_RST;
      vec_ptr_q  <= VECP_RST;
      ch_q       <= '0;
      pc_sav_q   <= '0;
      flg_sav_q  <= '0;
      pch_q      <= '0;
    end
    else
    begin
      code_seg_q <= code_seg_d;
      int_seg_q  <= int_seg_d;
      vec_ptr_q  <= vec_ptr_d;
      ch_q       <= ch_d;
      pc_sav_q   <= pc_sav_d;
      flg_sav_q  <= flg_sav_d;
      pch_q      <= pch_d;
    end
  end

  // Output flops; the fetch segment is registered from next values
  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
    begin
      ack_q   <= 1'b0;
      push_q  <= 1'b0;
      pop_q   <= 1'b0;
      swd_q   <= '0;
      vrd_q   <= 1'b0;
      vaddr_q <= '0;
      pcl_q   <= 1'b0;
      pcv_q   <= '0;
      fll_q   <= 1'b0;
      flv_q   <= '0;
      fseg_q  <= SEG_RST;
      rdata_q <= '0;
      busy_q  <= 1'b0;
    end
    else
    begin
      ack_q   <= ack_d;
      push_q  <= push_d;
      pop_q   <= pop_d;
      swd_q   <= swd_d;
      vrd_q   <= vrd_d;
      vaddr_q <= vaddr_d;
      pcl_q   <= pcl_d;
      pcv_q   <= pcv_d;
      fll_q   <= fll_d;
      flv_q   <= flv_d;
      fseg_q  <= alt_d ? int_seg_d : code_seg_d;                      // RL8
      rdata_q <= reg_rd ? rd_mux : '0;
      busy_q  <= (st_d != ST_IDLE);
    end
  end

  assign reg_rdata               = rdata_q;
  assign ack_pulse               = ack_q;
  assign ack_channel             = ch_q;
  assign stack_push              = push_q;
  assign stack_pop               = pop_q;
  assign stack_wdata             = swd_q;
  assign vec_read                = vrd_q;
  assign vec_addr                = vaddr_q;
  assign vec_segment             = int_seg_q;
  assign pc_load                 = pcl_q;
  assign pc_value                = pcv_q;
  assign flags_load              = fll_q;
  assign flags_value             = flv_q;
  assign fetch_segment           = fseg_q;
  assign busy                    = busy_q;
  assign global_interrupt_enable = gie_q;
  assign current_priority_level  = lvl_q;

  sequence s_push_pc;
    ##1 (stack_push && (stack_wdata == $past(pc_current[7:0], 2)))
    ##1 (stack_push && (stack_wdata == $past(pc_current[15:8], 3)));
  endsequence

  ack_disables_a: assert property (@(posedge clock) disable iff (!reset_n) // RL5
    take_ack |=> (ack_pulse && !gie_q))
    else $error("acknowledge did not clear the global enable");

  ack_strict_a: assert property (@(posedge clock) disable iff (!reset_n) // RL23
    ack_pulse |-> ($past(win_level) < $past(lvl_q)))
    else $error("acknowledged request not strictly above level");

  conc_level_a: assert property (@(posedge clock) disable iff (!reset_n) // RL3
    (!nested_q && !wr_ctrl) |=> (lvl_q == $past(lvl_q)))
    else $error("level changed by hardware in concurrent mode");

  push_order_a: assert property (@(posedge clock) disable iff (!reset_n) // RL6
    take_ack |=> s_push_pc)
    else $error("PC bytes pushed out of order");

  flag_push_a: assert property (@(posedge clock) disable iff (!reset_n) // RL6
    (take_ack && !sse_q && !wr_seg) |-> ##4 (stack_push
      && (stack_wdata == $past(flags_current, 4))) ##1 !stack_push)
    else $error("flags not pushed after PC");

  vec_load_a: assert property (@(posedge clock) disable iff (!reset_n) // RL7
    vec_read |=> ##1 (pc_load && (pc_value == $past(vec_data))))
    else $error("PC not loaded from vector");

  nest_save_a: assert property (@(posedge clock) disable iff (!reset_n) // RL17
    (take_ack && nested_q) |=> (nest_q[$past(lvl_q)]
      && (lvl_q == $past(win_level))))
    else $error("nested entry did not save and load the level");

  ret_enable_a: assert property (@(posedge clock) disable iff (!reset_n) // RL10
    take_ret |-> ##[10:13] (pc_load && gie_q))
    else $error("return did not restore PC and enable");

  nest_restore_a: assert property (@(posedge clock) disable iff (!reset_n) // RL25
    (pop_last && nested_q && (nest_q != NEST_RST) && !wr_ctrl)
      |=> ((lvl_q == $past(restore_lvl))
      && ((nest_q & $past(nest_low)) == NEST_RST)))
    else $error("level not restored from lowest stack bit");

  seg_return_a: assert property (@(posedge clock) disable iff (!reset_n) // RL11
    (pop_last && !sse_q && !nested_q && !wr_code) |=> ##1
      (fetch_segment == code_seg_q))
    else $error("fetch did not return to code segment");

endmodule : ias_sequencer

`default_nettype wire

// ### verification/ias_stack_model.sv
// Behavioural system stack and vector table beside the sequencer
`default_nettype none

module ias_stack_model
  import ias_pkg::*;
(
  // Clock and reset
  input  wire logic              clock,
  input  wire logic              reset_n,
  // System stack
  input  wire logic              stack_push,
  input  wire logic              stack_pop,
  input  wire logic [DATA_W-1:0] stack_wdata,
  output logic [DATA_W-1:0]      stack_rdata,
  // Vector table
  input  wire logic              vec_read,
  input  wire logic [DATA_W-1:0] vec_addr,
  input  wire logic [DATA_W-1:0] vec_segment,
  output logic [PC_W-1:0]        vec_data
);
  timeunit 1ns;
  timeprecision 1ns;

  logic [DATA_W-1:0] mem [0:15];
  logic [3:0]        sp_q;

  // Lines not answering show the inverse, so a late sample never matches
  always @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
    begin
      sp_q <= 4'h0;
      stack_rdata <= 8'h00;
      vec_data <= 16'h0000;
    end
    else
    begin
      stack_rdata <= ~stack_rdata;
      vec_data <= ~vec_data;
      if (stack_push)
      begin
        mem[sp_q] <= stack_wdata;
        sp_q <= sp_q + 4'h1;
      end
      if (stack_pop)
      begin
        stack_rdata <= mem[sp_q - 4'h1];
        sp_q <= sp_q - 4'h1;
      end
      // Vector value is its own location, so any wrong address shows
      if (vec_read)
        vec_data <= {vec_segment, vec_addr};
    end
  end
endmodule : ias_stack_model

`default_nettype wire

// ### verification/ias_sequencer_tb.sv
// Self-checking testbench of the interrupt arbitration sequencer
`default_nettype none

module ias_sequencer_tb
  import ias_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;

  logic clock = 1'b0, reset_n = 1'b0;
  logic [3:0] reg_addr, ack_channel;
  logic [7:0] reg_wdata, reg_rdata, flags_current, stack_wdata, stack_rdata;
  logic [7:0] vec_addr, vec_segment, flags_value, fetch_segment;
  logic reg_wr, reg_rd, instr_boundary, enable_irq_exec, irq_return_exec;
  logic ack_pulse, stack_push, stack_pop, vec_read, pc_load, flags_load, busy;
  logic global_interrupt_enable;
  logic [2:0]  current_priority_level;
  logic [15:0] req_pending, pc_current, vec_data, pc_value;
  logic [47:0] req_level;
  logic [31:0] pw;
  int errors = 0, checked = 0, acks = 0, lds = 0, flds = 0;

  always #5 clock = ~clock;

  ias_sequencer u_ias_sequencer (.clock, .reset_n, .reg_addr, .reg_wdata,
    .reg_wr, .reg_rd, .reg_rdata, .req_pending, .req_level, .instr_boundary,
    .enable_irq_exec, .irq_return_exec, .pc_current, .flags_current,
    .ack_pulse, .ack_channel, .stack_push, .stack_pop, .stack_wdata,
    .stack_rdata, .vec_read, .vec_addr, .vec_segment, .vec_data, .pc_load,
    .pc_value, .flags_load, .flags_value, .fetch_segment, .busy,
    .global_interrupt_enable, .current_priority_level);

  ias_stack_model u_ias_stack_model (.clock, .reset_n, .stack_push,
    .stack_pop, .stack_wdata, .stack_rdata, .vec_read, .vec_addr,
    .vec_segment, .vec_data);

  always @(posedge clock)
  begin
    if (stack_push === 1'b1)
      pw <= {pw[23:0], stack_wdata};
    if (ack_pulse === 1'b1)
      acks <= acks + 1;
    if (pc_load === 1'b1)
      lds <= lds + 1;
    if (flags_load === 1'b1)
      flds <= flds + 1;
  end

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checked++;
    if (g !== e)
    begin
      errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clock);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clock);
    reg_wr <= 1'b0;
  endtask : wr

  task automatic rd(input logic [3:0] a, input logic [7:0] e);
    @(posedge clock);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clock);
    reg_rd <= 1'b0;
    #1 chk(reg_rdata, e);
  endtask : rd

  // One instruction event, then wait until the sequence has settled
  task automatic op(input logic b, input logic e, input logic r);
    int n;
    @(posedge clock);
    instr_boundary <= b;
    enable_irq_exec <= e;
    irq_return_exec <= r;
    @(posedge clock);
    {instr_boundary, enable_irq_exec, irq_return_exec} <= 3'h0;
    n = 0;
    repeat (2) @(posedge clock);
    while (busy !== 1'b0 && n < 40)
    begin
      @(posedge clock);
      n++;
    end
    repeat (2) @(posedge clock);
    #1;
    chk(busy, 1'b0);
  endtask : op

  task automatic results;
    $display("errors=%0d checked=%0d", errors, checked);
    if (errors == 0 && checked > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : results

  initial
  begin
    #100000;
    errors++;
    results();
  end

  initial
  begin
    {reg_addr, reg_wdata, reg_wr, reg_rd} = '0;
    {instr_boundary, enable_irq_exec, irq_return_exec} = 3'h0;
    req_pending = 16'h0028;
    req_level = '1;
    req_level[11:9] = 3'h2;
    req_level[17:15] = 3'h1;
    pc_current = 16'h1234;
    flags_current = 8'hA5;
    pw = '0;
    repeat (8) @(posedge clock);
    reset_n <= 1'b1;
    rd(OFS_CTRL, 8'h07);
    rd(OFS_NEST, 8'h00);
    rd(4'hF, 8'h00);
    op(1'b1, 1'b0, 1'b0);
    chk(acks, 0);
    wr(OFS_INTSEG, 8'h40);
    wr(OFS_CODESEG, 8'h11);
    wr(OFS_VECPTR, 8'h20);
    wr(OFS_CTRL, 8'h14);
    op(1'b1, 1'b0, 1'b0);
    chk(ack_channel, 5);
    chk(global_interrupt_enable, 0);
    chk(current_priority_level, 4);
    chk(pw[23:0], 24'h3412A5);
    chk(pc_value, 16'h402A);
    chk(fetch_segment, 8'h40);
    op(1'b1, 1'b0, 1'b0);
    chk(acks, 1);
    op(1'b0, 1'b0, 1'b1);
    chk({pc_value, flags_value}, 24'h1234A5);
    chk(global_interrupt_enable, 1);
    chk(current_priority_level, 4);
    chk(fetch_segment, 8'h11);
    chk(lds, 2);
    chk(flds, 1);
    wr(OFS_SEGCFG, 8'h01);
    op(1'b1, 1'b0, 1'b0);
    chk(acks, 2);
    op(1'b0, 1'b1, 1'b0);
    op(1'b1, 1'b0, 1'b0);
    chk(acks, 3);
    chk(pw, 32'h341240A5);
    op(1'b0, 1'b0, 1'b1);
    op(1'b0, 1'b0, 1'b1);
    rd(OFS_CODESEG, 8'h11);
    wr(OFS_CTRL, 8'h34);
    op(1'b1, 1'b0, 1'b0);
    rd(OFS_NEST, 8'h10);
    chk(current_priority_level, 1);
    chk(pw, 32'h341211A5);
    rd(OFS_CODESEG, 8'h40);
    op(1'b0, 1'b1, 1'b0);
    op(1'b1, 1'b0, 1'b0);
    chk(acks, 4);
    @(posedge clock) req_level[11:9] <= 3'h0;
    op(1'b1, 1'b0, 1'b0);
    chk(ack_channel, 3);
    rd(OFS_NEST, 8'h12);
    chk(current_priority_level, 0);
    op(1'b0, 1'b0, 1'b1);
    chk(current_priority_level, 1);
    rd(OFS_NEST, 8'h10);
    op(1'b0, 1'b0, 1'b1);
    chk(current_priority_level, 4);
    rd(OFS_NEST, 8'h00);
    rd(OFS_CODESEG, 8'h11);
    results();
  end
endmodule : ias_sequencer_tb

`default_nettype wire
